/* File: serial_port_supply_monitor_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_port_supply_monitor_tb;
	import spsm_pkg::*;
	typedef struct {logic sup; logic smp; logic [7:0] en; logic [7:0] st;
		logic irq;} spsm_row_t;
	logic i_mclk = 1'b0, i_rst = 1'b1, i_sclk, i_cs_n, i_din;
	logic i_supply_low = 1'b0, i_energy_pulse = 1'b0, i_sample_rdy = 1'b0;
	logic [7:0] i_irq_enable = 8'h00, i_tx_byte = 8'h00;
	logic i_status_clr = 1'b0, i_tx_load = 1'b0;
	logic o_dout, o_dout_oe, o_irq_n_oe, o_active, o_rx_valid, o_tx_done;
	logic [7:0] o_status, o_rx_byte, rx;
	logic [15:0] o_energy, e1;
	logic oe;
	int error_cnt = 0, total_checks = 0, cyc = 0, rx_cnt = 0, tx_cnt = 0;
	spsm_row_t rows[3] = '{'{1'b0, 1'b1, 8'h04, 8'h04, 1'b1},
		'{1'b0, 1'b1, 8'h00, 8'h04, 1'b0}, '{1'b1, 1'b0, 8'hff, 8'h01, 1'b0}};
	spsm_top u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_sclk(i_sclk),
		.i_cs_n(i_cs_n), .i_din(i_din), .i_supply_low(i_supply_low),
		.i_energy_pulse(i_energy_pulse), .i_sample_rdy(i_sample_rdy),
		.i_irq_enable(i_irq_enable), .i_status_clr(i_status_clr),
		.i_tx_load(i_tx_load), .i_tx_byte(i_tx_byte), .o_dout(o_dout),
		.o_dout_oe(o_dout_oe), .o_irq_n_oe(o_irq_n_oe),
		.o_status(o_status), .o_active(o_active), .o_energy(o_energy),
		.o_rx_valid(o_rx_valid), .o_rx_byte(o_rx_byte),
		.o_tx_done(o_tx_done));
	spsm_host_model u_host (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_din(i_din),
		.i_dout(o_dout), .i_dout_oe(o_dout_oe));
	always #2.5 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (o_rx_valid === 1'b1) rx_cnt <= rx_cnt + 1;
		if (o_tx_done === 1'b1) tx_cnt <= tx_cnt + 1;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cycles(input int n);
		repeat (n) @(posedge i_mclk);
	endtask : cycles
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	initial begin
		cycles(3);
		chk({o_dout_oe, o_irq_n_oe, o_status, o_active, o_energy}, 0);
		cycles(3);
		i_rst <= 1'b0;
		cycles(3);
		$display("reset test done");
		foreach (rows[k]) begin
			i_irq_enable <= rows[k].en;
			i_supply_low <= rows[k].sup;
			i_sample_rdy <= rows[k].smp;
			cycles(1);
			i_sample_rdy <= 1'b0;
			cycles(6);
			chk(o_status, rows[k].st);
			chk(o_irq_n_oe, rows[k].irq);
			i_supply_low <= 1'b0;
			cycles(5);
			i_status_clr <= 1'b1;
			cycles(1);
			i_status_clr <= 1'b0;
			cycles(2);
			chk(o_status, STAT_RST);
		end
		$display("status table done");
		i_energy_pulse <= 1'b1;
		cycles(4);
		i_energy_pulse <= 1'b0;
		cycles(2);
		chk(o_energy != ACC_RST && o_active === 1'b1, 1);
		i_supply_low <= 1'b1;
		cycles(5);
		e1 = o_energy;
		i_energy_pulse <= 1'b1;
		cycles(4);
		i_energy_pulse <= 1'b0;
		cycles(2);
		chk({o_active, o_energy}, {1'b0, e1});
		i_supply_low <= 1'b0;
		cycles(5);
		$display("supply test done");
		u_host.frame(8'ha5, rx, oe);
		cycles(10);
		chk({rx_cnt[7:0], o_rx_byte}, {8'h01, 8'ha5});
		chk(oe, 0);
		i_tx_load <= 1'b1;
		i_tx_byte <= 8'h3c;
		cycles(1);
		i_tx_load <= 1'b0;
		cycles(4);
		u_host.frame(8'h5a, rx, oe);
		cycles(10);
		chk(rx, 8'h3c);
		chk({oe, o_dout_oe}, 0);
		chk({tx_cnt[7:0], o_rx_byte}, {8'h01, 8'h5a});
		$display("serial test done");
		print_verdict();
	end
endmodule : serial_port_supply_monitor_tb
`default_nettype wire

/* File: spsm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spsm_host_model (
	output logic      o_sclk,
	output logic      o_cs_n,
	output logic      o_din,
	input  wire logic i_dout,
	input  wire logic i_dout_oe
);
	logic pin;
	// The pin reads back the inverse of i_dout whenever the device is not driving it.
	assign pin = i_dout_oe ? i_dout : ~i_dout;
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_din  = 1'b0;
	end
	// Eleven clocks of 160 ns: two let a loaded byte cross into the link
	// clock, eight carry data, and the last must end the drive.
	task automatic frame(input logic [7:0] tx, output logic [7:0] rx,
		output logic oe_end);
		o_cs_n = 1'b0;
		#80.7;
		for (int i = 0; i < 11; i++) begin
			#40 o_din = (i < 8) ? tx[7 - i] : ~o_din;
			#40 o_sclk = 1'b1;
			#80 o_sclk = 1'b0;
			if (i >= 2 && i < 10) rx[9 - i] = pin;
		end
		oe_end = i_dout_oe;
		#80 o_cs_n = 1'b1;
		o_din = ~o_din;
		#160;
	endtask : frame
endmodule : spsm_host_model
`default_nettype wire

/* File: spsm_link.sv */
`timescale 1ns/1ps
`default_nettype none
module spsm_link
	import spsm_pkg::*;
(
	input  wire logic i_sclk,
	input  wire logic i_rst,
	input  wire logic i_cs_n,
	input  wire logic i_din,
	output logic      o_dout,
	output logic      o_dout_oe,
	spsm_xfer_if.link xf
);
	logic [FRAME_BITS-1:0] rx_sh_reg;
	logic [2:0]            rx_cnt_reg;
	logic                  rx_tgl_reg;
	logic [FRAME_BITS-1:0] tx_sh_reg;
	logic [2:0]            tx_cnt_reg;
	logic                  tx_seen_reg;
	logic                  tx_busy_reg;
	logic                  ack_reg;
	logic                  tx_tgl_s;
	logic [FRAME_BITS-1:0] rx_word;
	wire                   link_rst = i_rst | i_cs_n;
	wire                   tx_start = !tx_busy_reg && tx_seen_reg != tx_tgl_s;
	wire                   tx_last = tx_busy_reg && tx_cnt_reg == 3'h0;
	spsm_sync #(.W(1)) u_tsync (.i_clk(i_sclk), .i_rst(i_rst),
		.i_d(xf.tx_tgl), .o_q(tx_tgl_s));
	assign rx_word = {rx_sh_reg[FRAME_BITS-2:0], i_din};
	assign xf.rx_tgl = rx_tgl_reg;
	assign xf.rx_byte = rx_sh_reg;
	assign xf.tx_ack_tgl = ack_reg;
	// Input bits are captured on the falling serial clock edge.
	always_ff @(negedge i_sclk or posedge link_rst) begin
		if (link_rst) begin
			rx_sh_reg <= BYTE_RST;
			rx_cnt_reg <= 3'h0;
		end else begin
			rx_sh_reg <= rx_word;
			rx_cnt_reg <= rx_cnt_reg + 3'h1;
		end
	end
	always_ff @(negedge i_sclk or posedge i_rst) begin
		if (i_rst) begin
			rx_tgl_reg <= 1'b0;
		end else if (!i_cs_n && rx_cnt_reg == 3'h7) begin
			rx_tgl_reg <= ~rx_tgl_reg;
		end
	end
	// Handshake state survives deselection so a pending byte is not lost.
	always_ff @(posedge i_sclk or posedge i_rst) begin
		if (i_rst) begin
			tx_seen_reg <= 1'b0;
			ack_reg <= 1'b0;
		end else if (!i_cs_n) begin
			if (tx_start) begin
				tx_seen_reg <= tx_tgl_s;
			end
			if (tx_last) begin
				ack_reg <= ~ack_reg;
			end
		end
	end
	// Output bits launch on the rising edge; deselection floats the pin at
	// once, since the host may stop the serial clock after the frame.
	always_ff @(posedge i_sclk or posedge link_rst) begin
		if (link_rst) begin
			tx_sh_reg <= BYTE_RST;
			tx_cnt_reg <= 3'h0;
			tx_busy_reg <= 1'b0;
			o_dout <= 1'b0;
			o_dout_oe <= 1'b0;
		end else if (tx_start) begin
			tx_busy_reg <= 1'b1;
			tx_cnt_reg <= 3'h1;
			o_dout <= xf.tx_byte[FRAME_BITS-1];
			o_dout_oe <= 1'b1;
			tx_sh_reg <= {xf.tx_byte[FRAME_BITS-2:0], 1'b0};
		end else if (tx_busy_reg) begin
			o_dout <= tx_sh_reg[FRAME_BITS-1];
			tx_sh_reg <= {tx_sh_reg[FRAME_BITS-2:0], 1'b0};
			tx_cnt_reg <= tx_cnt_reg + 3'h1;
			if (tx_cnt_reg == 3'h0) begin
				tx_busy_reg <= 1'b0;
				o_dout_oe <= 1'b0;
			end
		end
	end
	property p_oe_only_selected;
		@(posedge i_sclk) disable iff (i_rst) i_cs_n |-> !o_dout_oe;
	endproperty
	a_oe_only_selected: assert property (p_oe_only_selected)
		else $error("data output driven while deselected");
	property p_oe_busy;
		@(posedge i_sclk) disable iff (i_rst)
			o_dout_oe |-> tx_busy_reg || $past(tx_busy_reg);
	endproperty
	a_oe_busy: assert property (p_oe_busy)
		else $error("data output driven with no byte to send");
	c_tx_start: cover property (@(posedge i_sclk) disable iff (i_rst)
		$rose(o_dout_oe));
endmodule : spsm_link
`default_nettype wire

/* File: spsm_pkg.sv */
package spsm_pkg;
	// Master clock rate assumed for specified operation.
	localparam int MCLK_HZ = 10_000_000;
	localparam int FRAME_BITS = 8;
	localparam int STAT_W = 8;
	// Status flag positions; the supply-reset flag never reaches the pin.
	localparam int STAT_SUPPLY_RST = 0;
	localparam int STAT_ENERGY_HALF = 1;
	localparam int STAT_SAMPLE_RDY = 2;
	localparam logic [STAT_W-1:0] STAT_RST = 8'h00;
	localparam logic [STAT_W-1:0] IRQ_MASKABLE = 8'hfe;
	localparam logic [FRAME_BITS-1:0] BYTE_RST = 8'h00;
	localparam logic [15:0] ACC_RST = 16'h0000;
	localparam logic [15:0] ACC_HALF = 16'h8000;
	typedef enum logic [1:0] {SPSM_IDLE, SPSM_RUN, SPSM_HALT} spsm_state_t;
endpackage : spsm_pkg

/* File: spsm_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module spsm_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_reg;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_reg <= '0;
			o_q <= '0;
		end else begin
			meta_reg <= i_d;
			o_q <= meta_reg;
		end
	end
endmodule : spsm_sync
`default_nettype wire

/* File: spsm_top.sv */
`timescale 1ns/1ps
`default_nettype none
module spsm_top
	import spsm_pkg::*;
(
	input  wire logic                          i_mclk,
	input  wire logic                          i_rst,
	input  wire logic                          i_sclk,
	input  wire logic                          i_cs_n,
	input  wire logic                          i_din,
	input  wire logic                          i_supply_low,
	input  wire logic                          i_energy_pulse,
	input  wire logic                          i_sample_rdy,
	input  wire logic [spsm_pkg::STAT_W-1:0]   i_irq_enable,
	input  wire logic                          i_status_clr,
	input  wire logic                          i_tx_load,
	input  wire logic [spsm_pkg::FRAME_BITS-1:0] i_tx_byte,
	output logic                               o_dout,
	output logic                               o_dout_oe,
	output logic                               o_irq_n_oe,
	output logic [spsm_pkg::STAT_W-1:0]        o_status,
	output logic                               o_active,
	output logic [15:0]                        o_energy,
	output logic                               o_rx_valid,
	output logic [spsm_pkg::FRAME_BITS-1:0]    o_rx_byte,
	output logic                               o_tx_done
);
	import spsm_pkg::*;
	spsm_xfer_if xf ();
	spsm_state_t           state_reg, state_next;
	logic                  low_s;
	logic                  cs_n_s;
	logic [2:0]            rxt_reg;
	logic [2:0]            ack_reg;
	logic                  rxt_s, ack_s;
	logic                  tx_tgl_reg;
	logic [FRAME_BITS-1:0] tx_byte_reg;
	logic [STAT_W-1:0]     status_reg, status_next, set_vec;
	logic [15:0]           acc_reg;
	wire                   rx_evt = rxt_reg[1] ^ rxt_reg[2];
	wire                   ack_evt = ack_reg[1] ^ ack_reg[2];
	wire                   running = (state_reg == SPSM_RUN);
	wire                   half_hit;
	wire                   irq_pending;
	// Link logic runs on the host serial clock only.
	spsm_link u_link (.i_sclk(i_sclk), .i_rst(i_rst), .i_cs_n(i_cs_n),
		.i_din(i_din), .o_dout(o_dout), .o_dout_oe(o_dout_oe), .xf(xf));
	spsm_sync #(.W(3)) u_psync (.i_clk(i_mclk), .i_rst(i_rst),
		.i_d({i_supply_low, i_cs_n, xf.rx_tgl}),
		.o_q({low_s, cs_n_s, rxt_s}));
	spsm_sync #(.W(1)) u_async (.i_clk(i_mclk), .i_rst(i_rst),
		.i_d(xf.tx_ack_tgl), .o_q(ack_s));
	assign xf.tx_tgl = tx_tgl_reg;
	assign xf.tx_byte = tx_byte_reg;
	assign half_hit = running && i_energy_pulse && (acc_reg == ACC_HALF - 16'h1);
	assign set_vec = {{(STAT_W-3){1'b0}}, i_sample_rdy && running,
		half_hit, low_s};
	// Sets win over the software clear.
	assign status_next = (status_reg & ~({STAT_W{i_status_clr}})) | set_vec;
	// Supply-reset flag is outside the maskable set.
	assign irq_pending = |(status_next & i_irq_enable & IRQ_MASKABLE);
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SPSM_IDLE: state_next = low_s ? SPSM_HALT : SPSM_RUN;
			SPSM_RUN:  if (low_s) state_next = SPSM_HALT;
			SPSM_HALT: if (!low_s) state_next = SPSM_RUN;
			default:   state_next = SPSM_IDLE;
		endcase
	end
	// Reset holds the core, and the link through its own reset.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= SPSM_IDLE;
			rxt_reg <= 3'h0;
			ack_reg <= 3'h0;
			tx_tgl_reg <= 1'b0;
			tx_byte_reg <= BYTE_RST;
			status_reg <= STAT_RST;
			acc_reg <= ACC_RST;
		end else begin
			state_reg <= state_next;
			rxt_reg <= {rxt_reg[1:0], rxt_s};
			ack_reg <= {ack_reg[1:0], ack_s};
			status_reg <= status_next;
			if (i_tx_load) begin
				tx_byte_reg <= i_tx_byte;
				tx_tgl_reg <= ~tx_tgl_reg;
			end
			if (running && i_energy_pulse) begin
				acc_reg <= acc_reg + 16'h1;
			end
		end
	end
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_irq_n_oe <= 1'b0;
			o_status <= STAT_RST;
			o_active <= 1'b0;
			o_energy <= ACC_RST;
			o_rx_valid <= 1'b0;
			o_rx_byte <= BYTE_RST;
			o_tx_done <= 1'b0;
		end else begin
			o_irq_n_oe <= irq_pending;
			o_status <= status_next;
			o_active <= (state_next == SPSM_RUN);
			o_energy <= acc_reg;
			o_rx_valid <= rx_evt && cs_n_s == 1'b0;
			if (rx_evt) begin
				o_rx_byte <= xf.rx_byte;
			end
			o_tx_done <= ack_evt;
		end
	end
	property p_low_halts;
		@(posedge i_mclk) disable iff (i_rst)
			state_reg == SPSM_HALT |-> ##1 $stable(acc_reg);
	endproperty
	a_low_halts: assert property (p_low_halts)
		else $error("energy accumulated while supply low");
	property p_low_flag;
		@(posedge i_mclk) disable iff (i_rst)
			low_s |=> status_reg[STAT_SUPPLY_RST];
	endproperty
	a_low_flag: assert property (p_low_flag)
		else $error("supply flag not set");
	property p_no_rst_irq;
		@(posedge i_mclk) disable iff (i_rst)
			(status_reg & i_irq_enable & IRQ_MASKABLE) == '0 && !i_sample_rdy
			&& !i_energy_pulse |=> !o_irq_n_oe;
	endproperty
	a_no_rst_irq: assert property (p_no_rst_irq)
		else $error("interrupt from supply flag");
	property p_irq;
		@(posedge i_mclk) disable iff (i_rst)
			|(status_next & i_irq_enable & IRQ_MASKABLE) |=> o_irq_n_oe;
	endproperty
	a_irq: assert property (p_irq)
		else $error("enabled event not signalled");
	property p_halt_inactive;
		@(posedge i_mclk) disable iff (i_rst)
			low_s ##1 low_s |=> !o_active;
	endproperty
	a_halt_inactive: assert property (p_halt_inactive)
		else $error("active while supply low");
	c_halt: cover property (@(posedge i_mclk) disable iff (i_rst)
		running ##1 state_reg == SPSM_HALT);
	c_rx: cover property (@(posedge i_mclk) disable iff (i_rst) o_rx_valid);
	c_irq: cover property (@(posedge i_mclk) disable iff (i_rst) $rose(o_irq_n_oe));
endmodule : spsm_top
`default_nettype wire

/* File: spsm_xfer_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface spsm_xfer_if;
	import spsm_pkg::*;
	logic                  rx_tgl;
	logic [FRAME_BITS-1:0] rx_byte;
	logic                  tx_tgl;
	logic [FRAME_BITS-1:0] tx_byte;
	logic                  tx_ack_tgl;
	modport link (output rx_tgl, output rx_byte, input tx_tgl,
		input tx_byte, output tx_ack_tgl);
	modport core (input rx_tgl, input rx_byte, output tx_tgl,
		output tx_byte, input tx_ack_tgl);
endinterface : spsm_xfer_if
`default_nettype wire
